// ---- srpd_pkg.sv ----
// package of constants and the per-bank row state tracker
`timescale 1ns/10ps
package srpd_pkg;
    // register word addresses on the avalon slave
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_FLAGS = 4'h2;
    localparam logic [3:0] REG_REFCNT = 4'h3;
    localparam logic [3:0] REG_MODE = 4'h4;
    // control register field positions
    localparam int CTRL_TRP_LSB = 0;
    localparam int CTRL_TRFC_LSB = 8;
    // status register field positions
    localparam int ST_OPEN_LSB = 0;
    localparam int ST_PRECHG_LSB = 8;
    localparam int ST_REF_BIT = 16;
    localparam int ST_SELF_BIT = 17;
    localparam int ST_DLLDIS_BIT = 18;
    localparam int ST_LOCKING_BIT = 19;
    localparam int ST_WRGUARD_BIT = 20;
    // sticky flag positions, cleared by writing one
    localparam int FL_LATBAD_BIT = 0;
    localparam int FL_EARLYWR_BIT = 1;
    localparam int FL_BUSYCMD_BIT = 2;
    // mode register bit positions
    localparam int MR1_DLL_OFF_BIT = 0;
    localparam int MR0_DLL_RST_BIT = 8;
    // clock and timing figures
    localparam int MCLK_HZ = 20000000;
    localparam int MCLK_PERIOD_NS = 1000000000 / MCLK_HZ;
    localparam int T_RP_NS = 15;
    localparam int T_RFC_NS = 160;
    localparam int T_REFI_NS = 7800;
    localparam int T_RP_CYC = (T_RP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int T_RFC_CYC = (T_RFC_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int T_REFI_CYC = T_REFI_NS / MCLK_PERIOD_NS;
    localparam int WR_GUARD_CYC = 512;
    localparam int DLLK_CYC = 512;
    localparam int AP_DELAY_CYC = 4;
    localparam int DLL_OFF_CL = 6;
    localparam int DLL_OFF_CWL = 6;
    // reset values
    localparam logic [7:0] TRP_RESET = 8'(T_RP_CYC);
    localparam logic [7:0] TRFC_RESET = 8'(T_RFC_CYC);
    // command codes on {ras_n, cas_n, we_n} with chip select low
    typedef enum logic [2:0] {
        CMD_MRS = 3'h0, CMD_REF = 3'h1, CMD_PRE = 3'h2, CMD_ACT = 3'h3,
        CMD_WR = 3'h4, CMD_RD = 3'h5, CMD_ZQ = 3'h6, CMD_NOP = 3'h7
    } srpd_cmd_t;
endpackage

// one bank: open flag, precharge timer and pending auto precharge
module srpd_bank
    import srpd_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic act,
    input wire logic pre,
    input wire logic ap_start,
    input wire logic [7:0] trp_cycles,
    output logic open_ff,
    output logic prechg_ff
);
    logic [7:0] trp_cnt_ff;
    logic [7:0] ap_cnt_ff;
    logic ap_pend_ff;
    logic ap_fire;

    assign ap_fire = ap_pend_ff && (ap_cnt_ff == 8'h00);

    // auto precharge waits out the burst before closing the row
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ap_pend_ff <= 1'b0;
            ap_cnt_ff <= 8'h00;
        end else if (ap_start) begin
            ap_pend_ff <= 1'b1;
            ap_cnt_ff <= 8'(AP_DELAY_CYC - 1);
        end else if (ap_fire) begin
            ap_pend_ff <= 1'b0;
        end else if (ap_pend_ff) begin
            ap_cnt_ff <= ap_cnt_ff - 8'h01;
        end
    end

    // row state: an idle bank ignores a precharge, a precharging one restarts its timer
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            open_ff <= 1'b0;
            prechg_ff <= 1'b0;
            trp_cnt_ff <= 8'h00;
        end else if (act) begin
            open_ff <= 1'b1;
            prechg_ff <= 1'b0;
        end else if ((pre && (open_ff || prechg_ff)) || (ap_fire && open_ff)) begin
            open_ff <= 1'b0;
            prechg_ff <= 1'b1;
            trp_cnt_ff <= (trp_cycles == 8'h00) ? 8'h00 : trp_cycles - 8'h01;
        end else if (prechg_ff) begin
            if (trp_cnt_ff == 8'h00) begin
                prechg_ff <= 1'b0;
            end else begin
                trp_cnt_ff <= trp_cnt_ff - 8'h01;
            end
        end
    end
endmodule

// ---- srpd_core.sv ----
// command decode for precharge, refresh, self refresh and dll-off modes
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/10ps

// Summary of operation
// - precharge closes one or all banks; bank busy for the precharge time.
// - a10 picks all banks; otherwise bank address picks the single bank.
// - precharge to idle bank is a no-op; to a precharging bank it restarts the timer, so the last one times it.
// - refresh is per command; row address comes from an internal counter.
// - refresh starts at the registering edge and lasts the refresh cycle time.
// - self refresh keeps data with no clock; writes wait 512 clocks after exit.
// - with dll off only read and write latency six are supported.
// - with dll off read strobe starts one cycle earlier, al plus cl minus one.
// - nop and deselect start nothing and disturb nothing running.
module srpd_core
    import srpd_pkg::*;
#(
    parameter int NBANK = 8,
    parameter int REFI_CYC = T_REFI_CYC,
    parameter int GUARD_CYC = WR_GUARD_CYC,
    parameter int LOCK_CYC = DLLK_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [13:0] addr,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic rd_strobe_start,
    output logic [NBANK-1:0] bank_open,
    output logic refresh_active,
    output logic self_refresh,
    output logic dll_disabled
);
    // pins pass two flip-flops before any logic reads them
    logic [21:0] pin_meta_ff;
    logic [21:0] pin_sync_ff;
    logic cke_prev_ff;
    logic s_cke;
    logic s_cs_n;
    logic [2:0] s_cmd;
    logic [2:0] s_ba;
    logic [13:0] s_addr;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pin_meta_ff <= 22'h000000;
            pin_sync_ff <= 22'h000000;
            cke_prev_ff <= 1'b0;
        end else begin
            pin_meta_ff <= {cke, cs_n, ras_n, cas_n, we_n, ba, addr};
            pin_sync_ff <= pin_meta_ff;
            cke_prev_ff <= pin_sync_ff[21];
        end
    end

    assign s_cke = pin_sync_ff[21];
    assign s_cs_n = pin_sync_ff[20];
    assign s_cmd = pin_sync_ff[19:17];
    assign s_ba = pin_sync_ff[16:14];
    assign s_addr = pin_sync_ff[13:0];

    // command strobes; deselect and nop decode to nothing at all
    logic cmd_ok;
    logic do_pre;
    logic do_act;
    logic do_rd;
    logic do_wr;
    logic do_ref;
    logic do_mrs;
    logic sr_enter;
    logic sr_exit;
    logic busy_cmd;

    assign cmd_ok = cke_prev_ff && s_cke && !s_cs_n && !self_refresh;
    assign do_pre = cmd_ok && (s_cmd == CMD_PRE);
    assign do_act = cmd_ok && (s_cmd == CMD_ACT);
    assign do_rd = cmd_ok && (s_cmd == CMD_RD);
    assign do_wr = cmd_ok && (s_cmd == CMD_WR);
    assign do_ref = cmd_ok && (s_cmd == CMD_REF) && !refresh_active;
    assign do_mrs = cmd_ok && (s_cmd == CMD_MRS);
    assign sr_enter = cke_prev_ff && !s_cke && !s_cs_n && (s_cmd == CMD_REF) && !self_refresh;
    assign sr_exit = self_refresh && s_cke;
    assign busy_cmd = cmd_ok && refresh_active && (s_cmd != CMD_NOP);

    // control register: precharge and refresh cycle counts
    logic [7:0] trp_ff;
    logic [7:0] trfc_ff;
    logic bus_wr;
    logic bus_rd;

    assign bus_wr = avs_write && !avs_waitrequest;
    assign bus_rd = avs_read && avs_waitrequest;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            trp_ff <= TRP_RESET;
            trfc_ff <= TRFC_RESET;
        end else if (bus_wr && (avs_address == REG_CTRL)) begin
            if (avs_byteenable[0]) begin
                trp_ff <= avs_writedata[CTRL_TRP_LSB +: 8];
            end
            if (avs_byteenable[1]) begin
                trfc_ff <= avs_writedata[CTRL_TRFC_LSB +: 8];
            end
        end
    end

    // per-bank trackers, a10 selects all banks
    logic [NBANK-1:0] bank_open_w;
    logic [NBANK-1:0] bank_prechg_w;

    genvar gb;
    generate
        for (gb = 0; gb < NBANK; gb++) begin : g_bank
            logic sel;
            assign sel = (s_ba == 3'(gb));
            srpd_bank u_bank (
                .mclk(mclk),
                .reset_n(reset_n),
                .act(do_act && sel),
                .pre(do_pre && (s_addr[10] || sel)),
                .ap_start((do_rd || do_wr) && s_addr[10] && sel),
                .trp_cycles(trp_ff),
                .open_ff(bank_open_w[gb]),
                .prechg_ff(bank_prechg_w[gb])
            );
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bank_open <= '0;
        end else begin
            bank_open <= bank_open_w;
        end
    end

    // refresh cycle timer and internal row address
    logic [7:0] rfc_cnt_ff;
    logic [15:0] ref_row_ff;
    logic [15:0] refi_cnt_ff;
    logic self_tick;

    assign self_tick = self_refresh && (refi_cnt_ff == 16'h0000);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            refresh_active <= 1'b0;
            rfc_cnt_ff <= 8'h00;
        end else if (do_ref) begin
            refresh_active <= 1'b1;
            rfc_cnt_ff <= (trfc_ff == 8'h00) ? 8'h00 : trfc_ff - 8'h01;
        end else if (refresh_active) begin
            if (rfc_cnt_ff == 8'h00) begin
                refresh_active <= 1'b0;
            end else begin
                rfc_cnt_ff <= rfc_cnt_ff - 8'h01;
            end
        end
    end

    // divider paces internal refreshes while in self refresh
    always_ff @(posedge mclk) begin
        if (!reset_n || !self_refresh || self_tick) begin
            refi_cnt_ff <= 16'(REFI_CYC - 1);
        end else begin
            refi_cnt_ff <= refi_cnt_ff - 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ref_row_ff <= 16'h0000;
        end else if (do_ref || self_tick) begin
            ref_row_ff <= ref_row_ff + 16'h0001;
        end
    end

    // self refresh state and the write guard after exit
    logic [9:0] guard_cnt_ff;
    logic wr_guard_ff;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            self_refresh <= 1'b0;
        end else if (sr_enter) begin
            self_refresh <= 1'b1;
        end else if (sr_exit) begin
            self_refresh <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            wr_guard_ff <= 1'b0;
            guard_cnt_ff <= 10'h000;
        end else if (sr_exit) begin
            wr_guard_ff <= 1'b1;
            guard_cnt_ff <= 10'(GUARD_CYC - 1);
        end else if (wr_guard_ff) begin
            if (guard_cnt_ff == 10'h000) begin
                wr_guard_ff <= 1'b0;
            end else begin
                guard_cnt_ff <= guard_cnt_ff - 10'h001;
            end
        end
    end

    // mode registers, dll disable and dll reset lock timer
    logic [13:0] mr0_ff;
    logic [13:0] mr1_ff;
    logic [13:0] mr2_ff;
    logic [9:0] lock_cnt_ff;
    logic locking_ff;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            mr0_ff <= 14'h0000;
            mr1_ff <= 14'h0000;
            mr2_ff <= 14'h0000;
        end else if (do_mrs) begin
            case (s_ba)
                3'h0: mr0_ff <= s_addr;
                3'h1: mr1_ff <= s_addr;
                3'h2: mr2_ff <= s_addr;
                default: mr0_ff <= mr0_ff;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            dll_disabled <= 1'b0;
        end else begin
            dll_disabled <= mr1_ff[MR1_DLL_OFF_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            locking_ff <= 1'b0;
            lock_cnt_ff <= 10'h000;
        end else if (do_mrs && (s_ba == 3'h0) && s_addr[MR0_DLL_RST_BIT]) begin
            locking_ff <= 1'b1;
            lock_cnt_ff <= 10'(LOCK_CYC - 1);
        end else if (locking_ff) begin
            if (lock_cnt_ff == 10'h000) begin
                locking_ff <= 1'b0;
            end else begin
                lock_cnt_ff <= lock_cnt_ff - 10'h001;
            end
        end
    end

    // latencies; dll-off forces cas latency six and an early strobe reference
    logic [4:0] cl;
    logic [4:0] cwl;
    logic [4:0] al;
    logic [4:0] rd_dly;
    logic lat_bad;
    logic [31:0] rd_pipe_ff;

    assign cl = dll_disabled ? 5'(DLL_OFF_CL) : 5'({2'b00, mr0_ff[6:4]} + 5'h04);
    assign cwl = 5'({2'b00, mr2_ff[5:3]} + 5'h05);
    assign al = (mr1_ff[4:3] == 2'h1) ? cl - 5'h01 :
                (mr1_ff[4:3] == 2'h2) ? cl - 5'h02 : 5'h00;
    assign rd_dly = dll_disabled ? al + cl - 5'h01 : al + cl;
    assign lat_bad = dll_disabled && (({2'b00, mr0_ff[6:4]} + 5'h04 != 5'(DLL_OFF_CL)) ||
                     (cwl != 5'(DLL_OFF_CWL)));

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rd_pipe_ff <= 32'h00000000;
            rd_strobe_start <= 1'b0;
        end else begin
            rd_pipe_ff <= (rd_pipe_ff >> 1) | (do_rd ? (32'h00000001 << (rd_dly - 5'h02)) :
                          32'h00000000);
            rd_strobe_start <= rd_pipe_ff[0];
        end
    end

    // sticky flags; a new event wins over a clear in the same cycle
    logic [2:0] flags_ff;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;

    assign flag_set = {busy_cmd, do_wr && wr_guard_ff, lat_bad && do_rd};
    assign flag_clr = (bus_wr && (avs_address == REG_FLAGS) && avs_byteenable[0]) ?
                      avs_writedata[2:0] : 3'h0;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            flags_ff <= 3'h0;
        end else begin
            flags_ff <= (flags_ff & ~flag_clr) | flag_set;
        end
    end

    // avalon slave: one wait state, then data and waitrequest low together
    logic [31:0] nxt_rdata;

    always_comb begin
        nxt_rdata = 32'h00000000;
        case (avs_address)
            REG_CTRL: begin
                nxt_rdata[CTRL_TRP_LSB +: 8] = trp_ff;
                nxt_rdata[CTRL_TRFC_LSB +: 8] = trfc_ff;
            end
            REG_STATUS: begin
                nxt_rdata[ST_OPEN_LSB +: NBANK] = bank_open_w;
                nxt_rdata[ST_PRECHG_LSB +: NBANK] = bank_prechg_w;
                nxt_rdata[ST_REF_BIT] = refresh_active;
                nxt_rdata[ST_SELF_BIT] = self_refresh;
                nxt_rdata[ST_DLLDIS_BIT] = dll_disabled;
                nxt_rdata[ST_LOCKING_BIT] = locking_ff;
                nxt_rdata[ST_WRGUARD_BIT] = wr_guard_ff;
            end
            REG_FLAGS: nxt_rdata[2:0] = flags_ff;
            REG_REFCNT: nxt_rdata[15:0] = ref_row_ff;
            REG_MODE: nxt_rdata = {2'b00, mr1_ff, 2'b00, mr0_ff};
            default: nxt_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            avs_readdata <= 32'h00000000;
        end else if (bus_rd) begin
            avs_readdata <= nxt_rdata;
        end
    end
endmodule

// ---- srpd_ctl_model.sv ----
// controller-side model driving the command pins
`timescale 1ns/10ps
module srpd_ctl_model
    import srpd_pkg::*;
(
    input wire logic mclk,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [2:0] ba,
    output logic [13:0] addr
);
    // idle: deselected, clock enabled
    initial begin
        cke = 1'b1;
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = 3'h7;
        ba = 3'h0;
        addr = 14'h0000;
    end
    // one command for one cycle, then deselect; released lines show inverse
    task automatic cmd(input srpd_cmd_t c, input logic [2:0] b, input logic [13:0] a);
        @(posedge mclk);
        cke <= 1'b1;
        cs_n <= 1'b0;
        {ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        @(posedge mclk);
        cs_n <= 1'b1;
        {ras_n, cas_n, we_n} <= 3'h7;
        ba <= ~b;
        addr <= ~a;
    endtask
    // refresh with cke falling enters self refresh, cke rising leaves it
    task automatic sref(input logic on);
        @(posedge mclk);
        cke <= !on;
        cs_n <= !on;
        {ras_n, cas_n, we_n} <= on ? CMD_REF : CMD_NOP;
        @(posedge mclk);
        cs_n <= 1'b1;
        {ras_n, cas_n, we_n} <= 3'h7;
    endtask
endmodule

// ---- srpd_core_assertions.sv ----
// checker on the precharge, refresh and mode block ports
`timescale 1ns/10ps
module srpd_core_chk
    import srpd_pkg::*;
#(
    parameter int NBANK = 8
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic rd_strobe_start,
    input wire logic [NBANK-1:0] bank_open,
    input wire logic refresh_active,
    input wire logic dll_disabled
);
    logic cv;
    logic [2:0] cm;
    logic [4:0] hit;
    logic [7:0] age_ff [5];
    // command kinds on the pins: act, close, refresh, mode set, any
    assign cv = cke && !cs_n;
    assign cm = {ras_n, cas_n, we_n};
    assign hit[0] = cv && cm == CMD_ACT;
    assign hit[1] = cv && (cm == CMD_PRE || cm == CMD_WR || cm == CMD_RD);
    assign hit[2] = !cs_n && cm == CMD_REF;
    assign hit[3] = cv && cm == CMD_MRS;
    assign hit[4] = !cs_n && cm != CMD_NOP;
    // cycles since the last command of each kind, saturating
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 5; i++) begin
            if (!reset_n) age_ff[i] <= 8'hff;
            else if (hit[i]) age_ff[i] <= 8'h00;
            else if (age_ff[i] != 8'hff) age_ff[i] <= age_ff[i] + 8'h01;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_strobe_pulse: assert property (rd_strobe_start |=> !rd_strobe_start)
        else $error("read strobe marker longer than one cycle");
    a_ref_cause: assert property ($rose(refresh_active) |-> age_ff[2] <= 8)
        else $error("refresh started without a refresh command");
    a_open_cause: assert property ((bank_open & ~$past(bank_open)) != 0 |-> age_ff[0] <= 8)
        else $error("bank opened without activate");
    a_close_cause: assert property ((~bank_open & $past(bank_open)) != 0 |-> age_ff[1] <= 16)
        else $error("bank closed without precharge");
    a_dll_cause: assert property (dll_disabled != $past(dll_disabled) |-> age_ff[3] <= 8)
        else $error("dll mode changed without mode set");
    a_nop_quiet: assert property (age_ff[4] > 20 |-> $stable(bank_open) && $stable(dll_disabled))
        else $error("state moved while only nop or deselect");
endmodule
bind srpd_core srpd_core_chk #(.NBANK(NBANK)) u_chk (
    .mclk(mclk), .reset_n(reset_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .rd_strobe_start(rd_strobe_start),
    .bank_open(bank_open), .refresh_active(refresh_active), .dll_disabled(dll_disabled)
);

// ---- tb_top.sv ----
// self-checking bench for the precharge, refresh and mode block
`timescale 1ns/10ps
module tb_top
    import srpd_pkg::*;
();
    logic mclk, reset_n, cke, cs_n, ras_n, cas_n, we_n;
    logic [2:0] ba;
    logic [13:0] addr;
    logic [3:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic rd_strobe_start, refresh_active, self_refresh, dll_disabled;
    logic [7:0] bank_open;
    int bad_count, checks_done, cyc, n, n_on, n_off;
    srpd_ctl_model ctl (.mclk(mclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
    srpd_core #(.GUARD_CYC(40), .LOCK_CYC(40)) uut (.mclk(mclk), .reset_n(reset_n),
        .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
        .addr(addr), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rd_strobe_start(rd_strobe_start),
        .bank_open(bank_open), .refresh_active(refresh_active),
        .self_refresh(self_refresh), .dll_disabled(dll_disabled));
    // 20 mhz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one bus transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 40);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) chk("waitrequest", 32'h0, 32'h1);
    endtask
    task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge mclk);
    endtask
    // cycles from a read command on the pins to the strobe marker
    task automatic rdlat(output int c);
        ctl.cmd(CMD_RD, 3'h0, 14'h0000);
        c = 2;
        while (rd_strobe_start !== 1'b1 && c < 60) begin
            @(posedge mclk);
            c++;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            wrap_up();
        end
    end
    initial begin
        bad_count = 0;
        checks_done = 0;
        cyc = 0;
        reset_n = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        wt(12);
        reset_n <= 1'b1;
        wt(3);
        // reset values, unmapped place, control write
        rd("ctrl", REG_CTRL, {16'h0000, TRFC_RESET, TRP_RESET});
        rd("status", REG_STATUS, 32'h0);
        bus(1'b1, 4'h5, 32'hffff_ffff);
        rd("unmapped", 4'h5, 32'h0);
        bus(1'b1, REG_CTRL, 32'h0000_0a14);
        rd("ctrl", REG_CTRL, 32'h0000_0a14);
        // open two banks, close one, retrigger its precharge
        ctl.cmd(CMD_ACT, 3'h2, 14'h0155);
        ctl.cmd(CMD_ACT, 3'h5, 14'h02aa);
        wt(8);
        chk("open", 32'h24, bank_open);
        ctl.cmd(CMD_PRE, 3'h2, 14'h0000);
        wt(10);
        chk("open", 32'h20, bank_open);
        ctl.cmd(CMD_PRE, 3'h2, 14'h0000);
        wt(10);
        rd("status", REG_STATUS, 32'h0000_0420);
        wt(14);
        rd("status", REG_STATUS, 32'h0000_0020);
        ctl.cmd(CMD_PRE, 3'h3, 14'h0000);
        wt(4);
        rd("status", REG_STATUS, 32'h0000_0020);
        ctl.cmd(CMD_PRE, 3'h3, 14'h0400);
        wt(8);
        chk("open", 32'h0, bank_open);
        wt(25);
        // refresh length, internal row, refresh during refresh refused
        ctl.cmd(CMD_REF, 3'h6, 14'h3fff);
        n = 0;
        repeat (30) begin
            @(posedge mclk);
            if (refresh_active === 1'b1) n++;
        end
        chk("refresh cycles", 32'd10, 32'(n));
        rd("refcnt", REG_REFCNT, 32'h1);
        ctl.cmd(CMD_REF, 3'h0, 14'h0000);
        wt(3);
        ctl.cmd(CMD_REF, 3'h0, 14'h0000);
        wt(20);
        rd("flags", REG_FLAGS, 32'h4);
        rd("refcnt", REG_REFCNT, 32'h2);
        bus(1'b1, REG_FLAGS, 32'h4);
        rd("flags", REG_FLAGS, 32'h0);
        // dll off, then self refresh, then the write guard
        ctl.cmd(CMD_MRS, 3'h1, 14'h0001);
        wt(8);
        chk("dll off", 32'h1, dll_disabled);
        ctl.sref(1'b1);
        wt(8);
        chk("self refresh", 32'h1, self_refresh);
        rd("status", REG_STATUS, 32'h0006_0000);
        ctl.sref(1'b0);
        wt(6);
        chk("self refresh", 32'h0, self_refresh);
        rd("status", REG_STATUS, 32'h0014_0000);
        ctl.cmd(CMD_WR, 3'h0, 14'h0000);
        wt(6);
        rd("flags", REG_FLAGS, 32'h2);
        bus(1'b1, REG_FLAGS, 32'h2);
        wt(40);
        rd("status", REG_STATUS, 32'h0004_0000);
        // read strobe reference: dll off, then dll on after reset and lock
        ctl.cmd(CMD_MRS, 3'h0, 14'h0020);
        ctl.cmd(CMD_ACT, 3'h0, 14'h0000);
        wt(8);
        rdlat(n_off);
        rd("flags", REG_FLAGS, 32'h1);
        bus(1'b1, REG_FLAGS, 32'h1);
        // write latency six as well, termination fields left at zero
        ctl.cmd(CMD_MRS, 3'h2, 14'h0008);
        ctl.cmd(CMD_RD, 3'h0, 14'h0000);
        wt(8);
        rd("flags", REG_FLAGS, 32'h0);
        ctl.cmd(CMD_MRS, 3'h1, 14'h0000);
        ctl.cmd(CMD_MRS, 3'h0, 14'h0120);
        wt(4);
        rd("status", REG_STATUS, 32'h0008_0001);
        wt(50);
        rdlat(n_on);
        chk("latency step", 32'h1, 32'(n_on - n_off));
        ctl.cmd(CMD_ACT, 3'h1, 14'h0000);
        ctl.cmd(CMD_RD, 3'h0, 14'h0400);
        ctl.cmd(CMD_RD, 3'h1, 14'h0000);
        wt(20);
        chk("open", 32'h2, bank_open);
        wrap_up();
    end
endmodule
